//--- hw/eeprom_cmd_map.svh
// Constants of the serial EEPROM command front end: opcodes, status
// layout, block protection bounds and write timing.
// Assumes inclusion by the design files of this block only.
`ifndef EEPROM_CMD_MAP_SVH
`define EEPROM_CMD_MAP_SVH

// Opcodes
`define OP_ARRAY_READ    8'h03
`define OP_ARRAY_WRITE   8'h02
`define STATUS_READ_CMD  8'h05
`define LATCH_SET_CMD    8'h06
`define LATCH_CLEAR_CMD  8'h04
`define STATUS_WRITE_CMD 8'h01

// Frame header lengths in bits (opcode, opcode plus 16-bit address)
`define HDR_SHORT        5'h08
`define HDR_LONG         5'h18
`define HDR_ADDR_LAST    5'h17
`define HDR_OP_LAST      5'h07

// Array geometry
`define ADDR_BITS        10
`define PAGE_OFS_BITS    5
`define PAGE_BYTES       32

// Status and control register fields
`define SR_PIN_PROTECT   7
`define SR_BP_HIGH       3
`define SR_BP_LOW        2
`define SR_WEL           1
`define SR_BUSY          0
`define SR_RESET         8'h00

// Block protect codes and lowest protected address
`define BP_NONE          2'h0
`define BP_QUARTER       2'h1
`define BP_HALF          2'h2
`define BP_ALL           2'h3
`define QUARTER_BASE     10'h300
`define HALF_BASE        10'h200

// Internal write cycle time and system clock rate
`define WRITE_TIME_US    5000
`define CLOCK_MHZ        100

`endif

//--- hw/eeprom_cmd_pkg.sv
// Types of the serial EEPROM command front end.
// Assumes the constants header is included by each user.
package eeprom_cmd_pkg;

  // Internal write sequencer, Gray along idle, wait, copy
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_COPY = 2'h3
  } commit_state_t;

  // Frame summary left by the link side for the commit side
  typedef struct packed {
    logic       cmd_ok;
    logic [7:0] cmd;
    logic       partial;
    logic       any_byte;
    logic [7:0] sr_data;
    logic [4:0] page;
  } frame_sum_t;

endpackage : eeprom_cmd_pkg

//--- hw/level_sync.sv
// Three-stage synchroniser for a group of independent levels.
// Assumes each bit is a slow level; a bit changes only once the
// second and third stages agree.
`timescale 1ns/1ps
module level_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] dout_ff;
  logic [W-1:0] nxt_dout;

  // Take stage two only where stages two and three agree
  assign nxt_dout = (s2_ff & ~(s2_ff ^ s3_ff)) | (dout_ff & (s2_ff ^ s3_ff));
  assign dout     = dout_ff;

  // Stage one feeds stage two and nothing else
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_ff   <= RST;
      s2_ff   <= RST;
      s3_ff   <= RST;
      dout_ff <= RST;
    end else begin
      s1_ff   <= din;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      dout_ff <= nxt_dout;
    end
  end
endmodule : level_sync

//--- hw/dual_clock_ram.sv
// Simple dual-port memory with separate write and read clocks.
// Assumes the two ports never touch one word in the same moment;
// read data come out of a register one read-clock edge after re.
`timescale 1ns/1ps
module dual_clock_ram #(
  parameter int W  = 8,
  parameter int D  = 32,
  parameter int AW = $clog2(D)
) (
  // Write port
  input  wire logic          wclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port
  input  wire logic          rclk,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [D];
  logic [W-1:0] rdata_ff;

  assign rdata = rdata_ff;

  // Write side
  always_ff @(posedge wclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read side
  always_ff @(posedge rclk) begin
    if (re) begin
      rdata_ff <= mem[raddr];
    end
  end
endmodule : dual_clock_ram

//--- hw/spi_eeprom_command_protect.sv
// Serial EEPROM command front end: SPI slave decode on the serial
// clock, status register, write protection and self-timed commit.
// Assumes the host keeps the serial clock still outside frames and
// changes the pause input only while the serial clock is low.
`timescale 1ns/1ps
`include "eeprom_cmd_map.svh"

// Summary of operation
// R1 - Serial input sampled on rising serial clock; modes (0,0) and (1,1).
// R2 - Serial output changes on falling serial clock edges.
// R3 - Chip select high: output high impedance, standby unless writing.
// R4 - Host opens frames with chip select falling, closes with rising.
// R5 - First eight bits form the opcode; only six opcodes act.
// R6 - Array read 03h, array write 02h, status read 05h.
// R7 - Latch set 06h, latch clear 04h, status write 01h.
// R8 - Status: pin protect 7, zeros 6-4, block bits 3-2, latch 1, busy 0.
// R9 - Busy reads one during the write cycle; host cannot write it.
// R10 - Latch set and clear commands; one permits writes.
// R11 - Block bits load only by status write and are non-volatile.
// R12 - Block code protects none, top quarter, top half or everything.
// R13 - Status write needs latch set and not pin-protected.
// R14 - Array write needs latch set and address outside protected range.
// R15 - Host sends latch set as a whole frame before each write.
// R16 - Address is 16 bits; only the low ten are used.
// R17 - Commit starts at chip select rise; busy accepts only status read.
// R18 - Page load increments in-page offset and wraps within the page.
// R19 - Latch clears when a write cycle ends and at power-up.
// R20 - Status write changes only bits 2, 3 and 7.
// R21 - Protect pin falling in a status write frame aborts it.
// R22 - Host changes the pause input only while serial clock is low.
// R23 - While paused, output high impedance and serial input ignored.
// R24 - Array read streams bytes, incrementing and wrapping the address.
// R25 - Status read answers at any time with the whole register.
// R26 - Undefined opcode: no action, output stays high impedance.
// R27 - Parameterised counter times the write cycle, then commits.
module spi_eeprom_command_protect #(
  parameter int unsigned WRITE_CYCLES = `WRITE_TIME_US * `CLOCK_MHZ
) (
  // System clock and power-on reset
  input  wire logic clock,
  input  wire logic rstn,
  // Serial link from the host
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic hold_n,
  input  wire logic wp_n,
  // Serial output pin, enable low while driving
  output logic      so,
  output logic      so_oe_n
);
  // Link side state
  logic        frame_rst_n;
  logic [4:0]  hdr_cnt_ff;
  logic [2:0]  bit_ff;
  logic [15:0] shift_ff;
  logic [7:0]  cmd_ff;
  logic        cmd_ok_ff;
  logic        tgl_ff;
  logic        partial_ff;
  logic        any_byte_ff;
  logic [7:0]  sr_data_ff;
  logic [4:0]  page_ff;
  logic [4:0]  ptr_ff;
  logic [31:0] pmask_ff;
  logic [9:0]  rd_addr_ff;
  logic        drv_ff;
  logic        so_ff;
  logic [7:0]  status_l;
  logic [7:0]  arr_rdata;
  // Link side decode
  logic [7:0]  byte_in;
  logic        first_edge;
  logic        op_done;
  logic        op_known;
  logic        op_allowed;
  logic        busy_l;
  logic        long_cmd;
  logic [4:0]  hdr_len;
  logic [4:0]  nxt_hdr;
  logic        in_data;
  logic        addr_last;
  logic        byte_end;
  logic        rd_ok;
  logic        wr_ok;
  logic        srw_ok;
  logic        srr_ok;
  logic [9:0]  full_addr;
  logic        arr_re;
  logic [9:0]  arr_raddr;
  logic        pbuf_we;
  logic [7:0]  cur_byte;
  // Commit side state
  eeprom_cmd_pkg::commit_state_t state_ff;
  eeprom_cmd_pkg::commit_state_t nxt_state;
  eeprom_cmd_pkg::frame_sum_t    sum;
  logic        tgl_s;
  logic        wp_s;
  logic        cs_s;
  logic        cs_d_ff;
  logic        seen_tgl_ff;
  logic        abort_ff;
  logic        wel_ff;
  logic [1:0]  bp_ff = `BP_NONE;
  logic        pin_protect_enable_ff = 1'b0;
  logic        kind_ff;
  logic [7:0]  sr_snap_ff;
  logic [31:0] wait_ff;
  logic [5:0]  idx_ff;
  logic [7:0]  pbuf_rdata;
  logic [7:0]  sr_byte;
  // Commit side decode
  logic        cs_rise;
  logic        cs_fall;
  logic        take;
  logic        set_wel;
  logic        clr_wel;
  logic        pin_lock;
  logic        start_sr;
  logic        start_arr;
  logic        wait_done;
  logic        cycle_done;
  logic        arr_we;
  logic [9:0]  arr_waddr;

  // Protected range for a block protect code
  function automatic logic prot_hit(input logic [1:0] bp,
                                    input logic [9:0] a);
    logic hit;
    hit = 1'b0;
    case (bp)
      `BP_QUARTER: hit = (a >= `QUARTER_BASE);
      `BP_HALF:    hit = (a >= `HALF_BASE);
      `BP_ALL:     hit = 1'b1;
      default:     hit = 1'b0;
    endcase
    return hit;
  endfunction : prot_hit

  // Frame-local state resets while chip select is high
  assign frame_rst_n = rstn & ~cs_n;

  // R5 R6 R7 opcode decode and busy gating
  assign byte_in    = {shift_ff[6:0], si};
  assign first_edge = (hdr_cnt_ff == 5'h00);
  assign op_done    = (hdr_cnt_ff == `HDR_OP_LAST);
  assign op_known   = (byte_in == `OP_ARRAY_READ)   ||
                      (byte_in == `OP_ARRAY_WRITE)  ||
                      (byte_in == `STATUS_READ_CMD) ||
                      (byte_in == `LATCH_SET_CMD)   ||
                      (byte_in == `LATCH_CLEAR_CMD) ||
                      (byte_in == `STATUS_WRITE_CMD);
  assign busy_l     = status_l[`SR_BUSY];
  // R17 only the status read passes while busy
  assign op_allowed = op_known &&
                      (!busy_l || byte_in == `STATUS_READ_CMD);

  // Header length, data phase and per-command qualifiers
  assign long_cmd  = (cmd_ff == `OP_ARRAY_READ) ||
                     (cmd_ff == `OP_ARRAY_WRITE);
  assign hdr_len   = long_cmd ? `HDR_LONG : `HDR_SHORT;
  assign nxt_hdr   = (hdr_cnt_ff == hdr_len) ? hdr_cnt_ff
                                             : hdr_cnt_ff + 5'h01;
  assign in_data   = cmd_ok_ff && (hdr_cnt_ff == hdr_len);
  assign addr_last = (hdr_cnt_ff == `HDR_ADDR_LAST);
  assign byte_end  = in_data && (bit_ff == 3'h7);
  assign rd_ok     = cmd_ok_ff && (cmd_ff == `OP_ARRAY_READ);
  assign wr_ok     = cmd_ok_ff && (cmd_ff == `OP_ARRAY_WRITE);
  assign srw_ok    = cmd_ok_ff && (cmd_ff == `STATUS_WRITE_CMD);
  assign srr_ok    = cmd_ok_ff && (cmd_ff == `STATUS_READ_CMD);
  // R16 upper address bits are ignored
  assign full_addr = {shift_ff[8:0], si};

  // R24 read the first byte at the last address bit, then one ahead
  assign arr_re    = hold_n && rd_ok && (addr_last || byte_end);
  assign arr_raddr = addr_last ? full_addr : rd_addr_ff + 10'h001;
  assign pbuf_we   = hold_n && wr_ok && byte_end;

  // R1 R23 sampling on rising edges, frozen while paused
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      hdr_cnt_ff <= 5'h00;
      bit_ff     <= 3'h0;
      shift_ff   <= 16'h0000;
    end else if (hold_n) begin
      hdr_cnt_ff <= nxt_hdr;
      bit_ff     <= in_data ? bit_ff + 3'h1 : 3'h0;
      shift_ff   <= {shift_ff[14:0], si};
    end
  end

  // Frame results that outlive chip select for the commit side
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      cmd_ff      <= 8'h00;
      cmd_ok_ff   <= 1'b0;
      tgl_ff      <= 1'b0;
      partial_ff  <= 1'b0;
      any_byte_ff <= 1'b0;
      sr_data_ff  <= 8'h00;
    end else if (hold_n) begin
      tgl_ff      <= first_edge ? ~tgl_ff : tgl_ff;
      partial_ff  <= in_data && (bit_ff != 3'h7);
      any_byte_ff <= !first_edge && (any_byte_ff || byte_end);
      // R5 R26 unknown opcodes leave the frame inert
      if (first_edge) begin
        cmd_ok_ff <= 1'b0;
      end else if (op_done) begin
        cmd_ok_ff <= op_allowed;
      end
      if (op_done) begin
        cmd_ff <= byte_in;
      end
      if (srw_ok && byte_end) begin
        sr_data_ff <= byte_in;
      end
    end
  end

  // R18 page load: fixed page, in-page offset wraps
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      page_ff    <= 5'h00;
      ptr_ff     <= 5'h00;
      pmask_ff   <= 32'h0000_0000;
      rd_addr_ff <= 10'h000;
    end else if (hold_n) begin
      if (wr_ok && addr_last) begin
        page_ff  <= full_addr[9:5];
        ptr_ff   <= full_addr[4:0];
        pmask_ff <= 32'h0000_0000;
      end else if (pbuf_we) begin
        ptr_ff           <= ptr_ff + 5'h01;
        pmask_ff[ptr_ff] <= 1'b1;
      end
      if (arr_re) begin
        rd_addr_ff <= arr_raddr;
      end
    end
  end

  // R25 status byte or array byte feeds the output shifter
  assign cur_byte = srr_ok ? status_l : arr_rdata;

  // R2 output changes on falling edges; paused output holds still
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      drv_ff <= 1'b0;
      so_ff  <= 1'b0;
    end else if (hold_n) begin
      drv_ff <= in_data && (rd_ok || srr_ok);
      so_ff  <= cur_byte[~bit_ff];
    end
  end

  // R3 R23 R26 release the pin unless selected, unpaused and answering
  assign so      = so_ff;
  assign so_oe_n = ~(drv_ff & ~cs_n & hold_n);

  // Status levels carried to the serial clock for status reads
  level_sync #(.W(8), .RST(`SR_RESET)) u_status_sync (
    .clock (sck),
    .rstn  (rstn),
    .din   (sr_byte),
    .dout  (status_l)
  );

  // Chip select, protect pin and frame toggle carried to the system clock
  level_sync #(.W(3), .RST(3'h3)) u_pin_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   ({tgl_ff, wp_n, cs_n}),
    .dout  ({tgl_s, wp_s, cs_s})
  );

  // Link results are still once chip select is high and the clock stops
  assign sum = '{cmd_ok: cmd_ok_ff, cmd: cmd_ff, partial: partial_ff,
                 any_byte: any_byte_ff, sr_data: sr_data_ff,
                 page: page_ff};

  // R4 R17 act on the chip select rise that closes a fresh frame
  assign cs_rise  = cs_s & ~cs_d_ff;
  assign cs_fall  = ~cs_s & cs_d_ff;
  assign take     = cs_rise && (tgl_s != seen_tgl_ff) && sum.cmd_ok &&
                    (state_ff == eeprom_cmd_pkg::ST_IDLE);
  // R10 R15 latch commands take effect on a whole frame
  assign set_wel  = take && (sum.cmd == `LATCH_SET_CMD);
  assign clr_wel  = take && (sum.cmd == `LATCH_CLEAR_CMD);
  // R13 R21 pin lock, including a protect pin fall during the frame
  assign pin_lock = pin_protect_enable_ff && (!wp_s || abort_ff);
  assign start_sr = take && (sum.cmd == `STATUS_WRITE_CMD) &&
                    sum.any_byte && !sum.partial && wel_ff && !pin_lock;
  // R14 array write needs the latch; protection is checked per byte
  assign start_arr = take && (sum.cmd == `OP_ARRAY_WRITE) &&
                     (pmask_ff != 32'h0000_0000) && !sum.partial &&
                     wel_ff;

  // R27 write cycle timer and page copy
  assign wait_done  = (state_ff == eeprom_cmd_pkg::ST_WAIT) &&
                      (wait_ff == 32'(WRITE_CYCLES - 1));
  assign cycle_done = (wait_done && kind_ff) ||
                      ((state_ff == eeprom_cmd_pkg::ST_COPY) &&
                       (idx_ff == 6'h20));
  assign arr_waddr  = {sum.page, 5'(idx_ff - 6'h01)};
  // R12 R14 protected bytes are skipped
  assign arr_we     = (state_ff == eeprom_cmd_pkg::ST_COPY) &&
                      (idx_ff != 6'h00) &&
                      pmask_ff[5'(idx_ff - 6'h01)] &&
                      !prot_hit(bp_ff, arr_waddr);

  // Next state of the write sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      eeprom_cmd_pkg::ST_IDLE: begin
        if (start_sr || start_arr) begin
          nxt_state = eeprom_cmd_pkg::ST_WAIT;
        end
      end
      eeprom_cmd_pkg::ST_WAIT: begin
        if (wait_done) begin
          nxt_state = kind_ff ? eeprom_cmd_pkg::ST_IDLE
                              : eeprom_cmd_pkg::ST_COPY;
        end
      end
      eeprom_cmd_pkg::ST_COPY: begin
        if (cycle_done) begin
          nxt_state = eeprom_cmd_pkg::ST_IDLE;
        end
      end
      default: nxt_state = eeprom_cmd_pkg::ST_IDLE;
    endcase
  end

  // R8 R9 status byte, busy from the sequencer only
  always_comb begin
    sr_byte                 = `SR_RESET;
    sr_byte[`SR_PIN_PROTECT] = pin_protect_enable_ff;
    sr_byte[`SR_BP_HIGH]    = bp_ff[1];
    sr_byte[`SR_BP_LOW]     = bp_ff[0];
    sr_byte[`SR_WEL]        = wel_ff;
    sr_byte[`SR_BUSY]       = (state_ff != eeprom_cmd_pkg::ST_IDLE);
  end

  // Sequencer, timer and frame tracking
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= eeprom_cmd_pkg::ST_IDLE;
      cs_d_ff     <= 1'b1;
      seen_tgl_ff <= 1'b0;
      abort_ff    <= 1'b0;
      wait_ff     <= 32'h0000_0000;
      idx_ff      <= 6'h00;
    end else begin
      state_ff    <= nxt_state;
      cs_d_ff     <= cs_s;
      seen_tgl_ff <= cs_rise ? tgl_s : seen_tgl_ff;
      // R21 a pin fall while selected wins over the frame-start clear
      abort_ff    <= (!cs_s && !wp_s) || (abort_ff && !cs_fall);
      wait_ff     <= (state_ff == eeprom_cmd_pkg::ST_WAIT) ?
                     wait_ff + 32'h0000_0001 : 32'h0000_0000;
      idx_ff      <= (state_ff == eeprom_cmd_pkg::ST_COPY) ?
                     idx_ff + 6'h01 : 6'h00;
    end
  end

  // R10 R19 latch: cleared at reset and when a write cycle ends
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wel_ff     <= 1'b0;
      kind_ff    <= 1'b0;
      sr_snap_ff <= 8'h00;
    end else begin
      if (cycle_done || clr_wel) begin
        wel_ff <= 1'b0;
      end else if (set_wel) begin
        wel_ff <= 1'b1;
      end
      if (start_sr || start_arr) begin
        kind_ff    <= start_sr;
        sr_snap_ff <= sum.sr_data;
      end
    end
  end

  // R11 R20 non-volatile bits: no power-on reset, loaded at commit only
  always_ff @(posedge clock) begin
    if (cycle_done && kind_ff) begin
      bp_ff   <= {sr_snap_ff[`SR_BP_HIGH], sr_snap_ff[`SR_BP_LOW]};
      pin_protect_enable_ff <= sr_snap_ff[`SR_PIN_PROTECT];
    end
  end

  // Array store: written by the commit, read on the serial clock
  dual_clock_ram #(.W(8), .D(1 << `ADDR_BITS)) u_array (
    .wclk  (clock),
    .we    (arr_we),
    .waddr (arr_waddr),
    .wdata (pbuf_rdata),
    .rclk  (sck),
    .re    (arr_re),
    .raddr (arr_raddr),
    .rdata (arr_rdata)
  );

  // Page buffer: loaded on the serial clock, drained by the commit
  dual_clock_ram #(.W(8), .D(`PAGE_BYTES)) u_page_buf (
    .wclk  (sck),
    .we    (pbuf_we),
    .waddr (ptr_ff),
    .wdata (byte_in),
    .rclk  (clock),
    .re    (state_ff == eeprom_cmd_pkg::ST_COPY),
    .raddr (idx_ff[4:0]),
    .rdata (pbuf_rdata)
  );

  // Checks on the commit side
  a_latch_end_clear: assert property (@(posedge clock) disable iff (!rstn) // R19
    cycle_done |=> !wel_ff) else $error("latch not cleared after write");
  a_busy_on_start: assert property (@(posedge clock) disable iff (!rstn) // R9
    (start_sr || start_arr) |=> sr_byte[`SR_BUSY] && !take)
    else $error("busy not set at write start");
  a_status_guard: assert property (@(posedge clock) disable iff (!rstn) // R13
    start_sr |-> wel_ff && !(pin_protect_enable_ff && (!wp_s || abort_ff)))
    else $error("status write started while refused");
  a_status_bits: assert property (@(posedge clock) disable iff (!rstn) // R20
    (cycle_done && kind_ff) |=> bp_ff == $past(sr_snap_ff[3:2]) &&
      pin_protect_enable_ff == $past(sr_snap_ff[7]) && !sr_byte[`SR_BUSY])
    else $error("status write loaded wrong bits");
  a_protect_skip: assert property (@(posedge clock) disable iff (!rstn) // R14
    arr_we |-> wel_ff && ((bp_ff == `BP_NONE) ||
      ((bp_ff == `BP_QUARTER) && (arr_waddr < `QUARTER_BASE)) ||
      ((bp_ff == `BP_HALF) && (arr_waddr < `HALF_BASE))))
    else $error("protected byte written");
  a_zero_fill: assert property (@(posedge clock) disable iff (!rstn) // R8
    sr_byte[6:4] == 3'h0) else $error("status bits 6-4 not zero");
  a_idle_quiet: assert property (@(posedge clock) disable iff (!rstn) // R3
    cs_n |-> so_oe_n) else $error("output driven while deselected");

  // Checks on the link side
  a_bad_opcode: assert property (@(posedge sck) disable iff (!rstn) // R26
    (op_done && hold_n && !op_known) |=> !cmd_ok_ff)
    else $error("undefined opcode accepted");
  a_busy_ignore: assert property (@(posedge sck) disable iff (!rstn) // R17
    (op_done && hold_n && busy_l && byte_in != `STATUS_READ_CMD)
      |=> !cmd_ok_ff) else $error("command taken while busy");
  a_page_wrap: assert property (@(posedge sck) disable iff (!rstn) // R18
    (pbuf_we && ptr_ff == 5'h1f && !addr_last) |=> ptr_ff == 5'h00)
    else $error("page offset did not wrap");
  a_pause_quiet: assert property (@(negedge sck) disable iff (!rstn) // R23
    !hold_n |-> so_oe_n) else $error("output driven while paused");

  // Main scenarios
  c_array_commit: cover property (@(posedge clock) disable iff (!rstn)
    start_arr ##[1:1000] cycle_done);
  c_status_commit: cover property (@(posedge clock) disable iff (!rstn)
    start_sr);
  c_status_poll: cover property (@(negedge sck) disable iff (!rstn)
    srr_ok && drv_ff && busy_l);
  c_read_stream: cover property (@(posedge sck) disable iff (!rstn)
    rd_ok && byte_end);

endmodule : spi_eeprom_command_protect

//--- testbench/spi_host_model.sv
// Host side model: SPI master sending whole-byte frames in mode (0,0).
// Assumes the device releases so by raising so_oe_n.
`timescale 1ns/1ps
module spi_host_model (
  // Serial link to the device
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so,
  input  wire logic so_oe_n
);
  // Released output floats, so a silent device reads as z
  wire line = so_oe_n ? 1'bz : so;
  // Bit index at which a frame pauses (none when negative), line seen then
  int         hold_at = -1;
  logic [7:0] held;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // cs_n framing, sck low when idle
  task automatic frame(input logic [63:0] tx, input int n,
                       output logic [7:0] rx);
    cs_n = 1'b0;
    #32;
    for (int i = 0; i < 8 * n; i++) begin
      // Pause and resume only while the serial clock is low
      if (i == hold_at) begin
        #16 hold_n = 1'b0;
        #64 held = {8{line}};
        hold_n = 1'b1;
      end
      si = tx[63 - i];
      #32 sck = 1'b1;
      rx = {rx[6:0], line};
      #32 sck = 1'b0;
    end
    #32 cs_n = 1'b1;
    si = ~si;  // Stale data never lingers on the line
    #200;
  endtask : frame
endmodule : spi_host_model

//--- testbench/spi_eeprom_command_protect_bench.sv
// Self-checking bench of the EEPROM command front end.
// Assumes a short write cycle and the host model on the link.
`timescale 1ns/1ps
module spi_eeprom_command_protect_bench;
  logic       clock, rstn, wp_n, sck, cs_n, si, hold_n, so, so_oe_n;
  logic [7:0] rx;
  int         n_errors = 0;
  int         checks = 0;

  spi_eeprom_command_protect #(.WRITE_CYCLES(300))
    spi_eeprom_command_protect_inst (.clock(clock), .rstn(rstn),
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so(so), .so_oe_n(so_oe_n));
  spi_host_model spi_host_model_inst (.sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic test_done;
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic [63:0] tx, input int n);
    spi_host_model_inst.frame(tx, n, rx);
  endtask : xfer

  // Poll the busy flag with a bounded number of status reads
  task automatic wait_ready;
    for (int i = 0; i < 40; i++) begin
      xfer({8'h05, 56'h0}, 2);
      if (rx[0] === 1'b0) return;
    end
    n_errors++;
    test_done;
  endtask : wait_ready

  // latch set as its own frame before each write
  task automatic wr_sr(input logic [7:0] v);
    xfer({8'h06, 56'h0}, 1);
    xfer({8'h01, v, 48'h0}, 2);
    wait_ready;
  endtask : wr_sr

  task automatic sc_latch;
    xfer({8'h05, 56'h0}, 2);
    chk("status after reset", rx, 8'h00);
    xfer({8'h06, 56'h0}, 1);
    spi_host_model_inst.hold_at = 12;
    xfer({8'h05, 56'h0}, 2);
    spi_host_model_inst.hold_at = -1;
    chk("latch set", rx, 8'h02);
    chk("paused output", spi_host_model_inst.held, 8'hzz);
    xfer({8'h04, 56'h0}, 1);
    xfer({8'h05, 56'h0}, 2);
    chk("latch clear", rx, 8'h00);
    xfer({8'hff, 56'h0}, 2);
    chk("unknown opcode output", rx, 8'hzz);
  endtask : sc_latch

  // Upper address bits are junk; the load runs off the page end and wraps
  task automatic sc_array;
    xfer({8'h06, 56'h0}, 1);
    xfer({8'h02, 16'hfb1f, 8'ha5, 8'hc3, 8'h96, 16'h0}, 6);
    wait_ready;
    xfer({8'h03, 16'h031f, 8'h00, 32'h0}, 4);
    chk("array byte", rx, 8'ha5);
    xfer({8'h03, 16'h0300, 8'h00, 32'h0}, 4);
    chk("page wrap", rx, 8'hc3);
    xfer({8'h03, 16'h0300, 16'h0, 24'h0}, 5);
    chk("streamed byte", rx, 8'h96);
    wr_sr(8'h04);
    xfer({8'h06, 56'h0}, 1);
    xfer({8'h02, 16'h0300, 8'h5a, 32'h0}, 4);
    wait_ready;
    xfer({8'h03, 16'h0300, 8'h00, 32'h0}, 4);
    chk("protected byte", rx, 8'hc3);
  endtask : sc_array

  task automatic sc_status;
    xfer({8'h01, 8'hff, 48'h0}, 2);
    xfer({8'h05, 56'h0}, 2);
    chk("write without latch", rx, 8'h04);
    xfer({8'h06, 56'h0}, 1);
    xfer({8'h01, 8'hff, 48'h0}, 2);
    xfer({8'h05, 56'h0}, 2);
    chk("busy flag", {7'h00, rx[0]}, 8'h01);
    // latch clear sent while busy must be ignored
    xfer({8'h04, 56'h0}, 1);
    wait_ready;
    xfer({8'h05, 56'h0}, 2);
    chk("status written", rx, 8'h8c);
    @(posedge clock);
    wp_n <= 1'b0;
    wr_sr(8'h00);
    chk("pin protected", rx & 8'hfc, 8'h8c);
    @(posedge clock);
    wp_n <= 1'b1;
    wr_sr(8'h00);
    chk("pin released", rx, 8'h00);
  endtask : sc_status

  initial begin
    rstn = 1'b0;
    wp_n = 1'b1;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (5) @(posedge clock);
    sc_latch;
    sc_array;
    sc_status;
    test_done;
  end
endmodule : spi_eeprom_command_protect_bench
